/* File: hw/twms_pkg.sv */
// Constants, field layouts, state codes and carrier structs of the two-wire controller.
// Assumes a single 125 MHz system clock and an external open-drain bus wrapper.
//
// Summary of operation
// - Writing master data after a write address clears write-done and shifts the byte.
// - Write-done sets again on byte completion, lost arbitration or bus error.
// - Received-ack status holds last ack bit, zero meaning ACK.
// - Master answers each read byte unless a target write restarts first; a collision while answering loses arbitration.
// - Quick command: direction bit is the command, no data bytes follow.
// - Quick command: acknowledged address sets read-done or write-done, then stop accepted.
// - A set slave data or address-or-stop flag holds the clock line low, unless a collision is flagged.
// - Slave takes address after start, acknowledges and stores a match, else waits.
// - Matching address or general call sets the address-or-stop flag.
// - Start immediately followed by stop sets the slave bus-error flag.
// - Slave direction flag equals the direction bit of the latest matching or general-call address.
// - Read address: hold clock; ACK requests transmit data, NACK waits for start.
// - Write address: hold clock; ACK waits for data, NACK waits for start.
// - Slave collision sets flag, releases data, ack and clock, still accepts start.
// - Stop closing an addressed transfer sets the address-or-stop flag, marked as stop.
// - Slave data flag after each received byte; NACK then expects stop or restart.
// - Slave data write sends a byte; flag when master ACKs it; master NACK ends sending.
// - Master auto mode with ACK selected sends ACK on data read; never auto NACK.
// - Slave auto mode clears the slave data flag on data read or write.
// - Slave request ORs data and address-or-stop; master request ORs read and write done.
// - Slave runs in sleep and stretches from start until clock returns; master halts.
// - Ack response select: 0 is ACK, 1 is NACK, default 0.
// - Command 1 ack then restart, 2 ack then next byte, 3 ack then stop.
// - Master target write starts a transaction once the bus is idle.
package twms_pkg;
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_RSTART = 2'h1;
  localparam logic [1:0] CMD_NEXT = 2'h2;
  localparam logic [1:0] CMD_STOP = 2'h3;
  localparam logic ACK_SEND = 1'h0;
  localparam logic ACK_SEL_RESET = 1'h0;
  localparam logic [8:0] HALF_BASE = 9'h005;
  localparam logic [6:0] GENERAL_CALL = 7'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] FRAME_BITS = 4'h9;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [3:0]
  {
    M_IDLE = 4'h0, M_WAIT = 4'h1, M_START = 4'h2, M_LOW = 4'h3, M_HIGH = 4'h4,
    M_HOLD = 4'h5, M_RSLO = 4'h6, M_RSHI = 4'h7, M_STLO = 4'h8, M_STHI = 4'h9
  } twms_mst_e;

  typedef enum logic [1:0]
  {
    P_ADDR = 2'h0, P_WDATA = 2'h1, P_RDATA = 2'h2, P_ACKOUT = 2'h3
  } twms_phase_e;

  typedef enum logic [2:0]
  {
    S_IDLE = 3'h0, S_ADDR = 3'h1, S_AACK = 3'h2, S_RXD = 3'h3, S_DACK = 3'h4,
    S_TXW = 3'h5, S_TXB = 3'h6
  } twms_sst_e;

  typedef struct packed
  {
    logic enable;
    logic quickCommandEnable;
    logic autoAckEnable;
    logic ackResponseSelect;
    logic readIntEnable;
    logic writeIntEnable;
    logic [7:0] baud;
  } twms_mctl_s;

  typedef struct packed
  {
    logic readDoneFlag;
    logic writeDoneFlag;
    logic clkHold;
    logic receivedAckStatus;
    logic arbitrationLostFlag;
    logic busErrorFlag;
  } twms_mstat_s;

  typedef struct packed
  {
    logic enable;
    logic autoAckEnable;
    logic ackResponseSelect;
    logic dataIntEnable;
    logic addrStopIntEnable;
    logic [6:0] address;
  } twms_sctl_s;

  typedef struct packed
  {
    logic slaveByteFlag;
    logic addrOrStopFlag;
    logic clkHold;
    logic receivedAckStatus;
    logic collisionFlag;
    logic busErrorFlag;
    logic direction;
    logic isAddress;
  } twms_sstat_s;
endpackage : twms_pkg

/* File: hw/twms_sync.sv */
// Two-stage synchroniser for bus pin inputs.
// Assumes inputs are asynchronous to mclk; only the last stage is read outside.
`timescale 1ns/100ps
module twms_sync #(
  parameter int WIDTH = 2
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1Q;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage1Q <= {WIDTH{1'b1}};
      syncOut <= {WIDTH{1'b1}};
    end
    else
    begin
      stage1Q <= asyncIn;
      syncOut <= stage1Q;
    end
  end
endmodule : twms_sync

/* File: hw/twms_top.sv */
// Two-wire bus master and slave with software-side control ports.
// Assumes an external open-drain wrapper; an enable high pulls the line low.
`timescale 1ns/100ps
module twms_top (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sclOut,
  output logic sclOe,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic sleepMode,
  input twms_pkg::twms_mctl_s mCtl,
  input wire logic targetWrite,
  input wire logic [7:0] targetData,
  input wire logic byteWrite,
  input wire logic [7:0] byteWriteData,
  input wire logic byteRead,
  input wire logic cmdWrite,
  input wire logic [1:0] cmdCode,
  output twms_pkg::twms_mstat_s mStat,
  output logic [7:0] masterByte,
  output logic masterIrq,
  input twms_pkg::twms_sctl_s sCtl,
  input wire logic slaveRespond,
  input wire logic slaveByteWrite,
  input wire logic [7:0] slaveByteWriteData,
  input wire logic slaveByteRead,
  output twms_pkg::twms_sstat_s sStat,
  output logic [7:0] slaveByte,
  output logic slaveIrq
);
  import twms_pkg::*;

  // ----------------------------------------------------------------
  // Bus monitor
  // ----------------------------------------------------------------
  logic [1:0] pinSync;
  logic sclP, sdaP, busBusyQ;
  twms_sync #(.WIDTH(SYNC_STAGES)) uSync (
    .mclk(mclk),
    .rst_b(rst_b),
    .asyncIn({sclIn, sdaIn}),
    .syncOut(pinSync)
  );
  wire sclS = pinSync[1];
  wire sdaS = pinSync[0];
  wire startDet = sclS & sclP & sdaP & ~sdaS;
  wire stopDet = sclS & sclP & ~sdaP & sdaS;
  wire sclRise = sclS & ~sclP;
  wire sclFall = ~sclS & sclP;

  // ----------------------------------------------------------------
  // Master registers
  // ----------------------------------------------------------------
  twms_mst_e mStQ, mStD;
  twms_phase_e phaseQ, phaseD;
  logic [8:0] tmrQ, tmrD, txQ, txD, rxQ, rxD;
  logic [3:0] nBitsQ, nBitsD;
  logic [7:0] addrQ, addrD, mByteQ, mByteD;
  logic [1:0] pendQ, pendD;
  logic dirQ, dirD, needAckQ, needAckD, mSclQ, mSclD, mSdaQ, mSdaD;
  logic rifQ, rifD, wifQ, wifD, arbQ, arbD, berQ, berD, rxAckQ, rxAckD, mHoldQ;
  wire [8:0] halfLimit = HALF_BASE + {1'b0, mCtl.baud};
  wire tmrDone = (tmrQ == 9'h000);
  wire ownBit = ((phaseQ == P_ADDR || phaseQ == P_WDATA) && nBitsQ != 4'h1)
    || phaseQ == P_ACKOUT;
  wire autoAck = byteRead & mCtl.autoAckEnable & (mCtl.ackResponseSelect == ACK_SEND);

  // ----------------------------------------------------------------
  // Master sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    mStD = mStQ;
    phaseD = phaseQ;
    tmrD = tmrDone ? tmrQ : tmrQ - 9'h001;
    txD = txQ;
    rxD = rxQ;
    nBitsD = nBitsQ;
    addrD = addrQ;
    mByteD = mByteQ;
    pendD = pendQ;
    dirD = dirQ;
    needAckD = needAckQ;
    mSclD = mSclQ;
    mSdaD = mSdaQ;
    rifD = rifQ;
    wifD = wifQ;
    arbD = arbQ;
    berD = berQ;
    rxAckD = rxAckQ;
    if (!mCtl.enable)
    begin
      mStD = M_IDLE;
      mSclD = 1'b0;
      mSdaD = 1'b0;
    end
    else if (!sleepMode)
    begin
      case (mStQ)
        M_IDLE:
        begin
          mSclD = 1'b0;
          mSdaD = 1'b0;
          if (targetWrite)
          begin
            addrD = targetData;
            dirD = targetData[0];
            {rifD, wifD, arbD, berD, needAckD} = 5'h00;
            mStD = M_WAIT;
          end
        end
        M_WAIT:
          if (!busBusyQ && sclS && sdaS)
          begin
            mSdaD = 1'b1;
            tmrD = halfLimit;
            mStD = M_START;
          end
        M_START:
          if (tmrDone)
          begin
            mSclD = 1'b1;
            txD = {addrQ, 1'b1};
            nBitsD = FRAME_BITS;
            phaseD = P_ADDR;
            tmrD = halfLimit;
            mStD = M_LOW;
          end
        M_LOW:
        begin
          mSdaD = ~txQ[8];
          if (tmrDone)
          begin
            mSclD = 1'b0;
            tmrD = halfLimit;
            mStD = M_HIGH;
          end
        end
        M_HIGH:
          if (!sclS)
            tmrD = halfLimit;
          else if (tmrDone)
          begin
            rxD = {rxQ[7:0], sdaS};
            txD = {txQ[7:0], 1'b1};
            nBitsD = nBitsQ - 4'h1;
            tmrD = halfLimit;
            mSclD = 1'b1;
            if (ownBit && txQ[8] && !sdaS)
            begin
              arbD = 1'b1;
              wifD = 1'b1;
              mSclD = 1'b0;
              mSdaD = 1'b0;
              mStD = M_IDLE;
            end
            else if (nBitsQ != 4'h1)
              mStD = M_LOW;
            else
            begin
              mStD = M_HOLD;
              case (phaseQ)
                P_ADDR:
                begin
                  rxAckD = sdaS;
                  if (!sdaS && dirQ && !mCtl.quickCommandEnable)
                  begin
                    phaseD = P_RDATA;
                    nBitsD = BYTE_BITS;
                    txD = 9'h1FF;
                    mStD = M_LOW;
                  end
                  else if (!sdaS && dirQ)
                    rifD = 1'b1;
                  else
                    wifD = 1'b1;
                end
                P_WDATA:
                begin
                  rxAckD = sdaS;
                  wifD = 1'b1;
                end
                P_RDATA:
                begin
                  mByteD = {rxQ[6:0], sdaS};
                  rifD = 1'b1;
                  needAckD = 1'b1;
                end
                default:
                begin
                  if (pendQ == CMD_NEXT)
                  begin
                    phaseD = P_RDATA;
                    nBitsD = BYTE_BITS;
                    txD = 9'h1FF;
                    mStD = M_LOW;
                  end
                  else
                    mStD = (pendQ == CMD_STOP) ? M_STLO : M_RSLO;
                end
              endcase
            end
          end
        M_HOLD:
        begin
          mSclD = 1'b1;
          tmrD = halfLimit;
          if (targetWrite)
          begin
            addrD = targetData;
            dirD = targetData[0];
            {rifD, wifD, arbD, berD, needAckD} = 5'h00;
            mStD = M_RSLO;
          end
          else if ((cmdWrite && cmdCode != CMD_NONE) || (autoAck && needAckQ))
          begin
            rifD = 1'b0;
            wifD = 1'b0;
            pendD = cmdWrite ? cmdCode : CMD_NEXT;
            if (needAckQ)
            begin
              txD = {mCtl.ackResponseSelect, 8'hFF};
              nBitsD = 4'h1;
              phaseD = P_ACKOUT;
              needAckD = 1'b0;
              mStD = M_LOW;
            end
            else if (cmdCode == CMD_STOP)
              mStD = M_STLO;
            else if (cmdCode == CMD_RSTART)
              mStD = M_RSLO;
            else if (dirQ && !mCtl.quickCommandEnable)
            begin
              phaseD = P_RDATA;
              nBitsD = BYTE_BITS;
              txD = 9'h1FF;
              mStD = M_LOW;
            end
          end
          else if (byteWrite && !dirQ && !mCtl.quickCommandEnable)
          begin
            wifD = 1'b0;
            txD = {byteWriteData, 1'b1};
            nBitsD = FRAME_BITS;
            phaseD = P_WDATA;
            mStD = M_LOW;
          end
        end
        M_RSLO:
        begin
          mSdaD = 1'b0;
          if (tmrDone)
          begin
            mSclD = 1'b0;
            tmrD = halfLimit;
            mStD = M_RSHI;
          end
        end
        M_RSHI:
          if (!sclS)
            tmrD = halfLimit;
          else if (tmrDone)
          begin
            mSdaD = 1'b1;
            tmrD = halfLimit;
            mStD = M_START;
          end
        M_STLO:
        begin
          mSdaD = 1'b1;
          if (tmrDone)
          begin
            mSclD = 1'b0;
            tmrD = halfLimit;
            mStD = M_STHI;
          end
        end
        M_STHI:
          if (!sclS)
            tmrD = halfLimit;
          else if (tmrDone)
          begin
            mSdaD = 1'b0;
            mStD = M_IDLE;
          end
        default:
          mStD = M_IDLE;
      endcase
      if ((mStQ == M_LOW || mStQ == M_HIGH) && (startDet || stopDet))
      begin
        {berD, arbD, wifD} = 3'h7;
        mSclD = 1'b0;
        mSdaD = 1'b0;
        mStD = M_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Slave registers
  // ----------------------------------------------------------------
  twms_sst_e sStQ, sStD;
  logic [3:0] sCntQ, sCntD;
  logic [7:0] sShQ, sShD, sTxQ, sTxD, sByteQ, sByteD;
  logic difQ, difD, apifQ, apifD, isAddrQ, isAddrD, sDirQ, sDirD, collQ, collD;
  logic sBerQ, sBerD, sRxAckQ, sRxAckD, sSdaQ, sSdaD, ackSelQ, ackSelD;
  logic respQ, sHoldQ, wakeQ;
  wire respond = slaveRespond
    | (sCtl.autoAckEnable & (slaveByteRead | slaveByteWrite));
  wire [7:0] inByte = {sShQ[6:0], sdaS};
  wire addrMatch = (inByte[7:1] == sCtl.address) || (inByte[7:1] == GENERAL_CALL);
  wire inAck = (sStQ == S_AACK) || (sStQ == S_DACK);

  // ----------------------------------------------------------------
  // Slave sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    sStD = sStQ;
    sCntD = sCntQ;
    sShD = sShQ;
    sTxD = sTxQ;
    sByteD = sByteQ;
    difD = difQ & ~respond;
    apifD = apifQ & ~respond;
    isAddrD = isAddrQ;
    sDirD = sDirQ;
    collD = collQ;
    sBerD = sBerQ;
    sRxAckD = sRxAckQ;
    sSdaD = sSdaQ;
    ackSelD = respond ? sCtl.ackResponseSelect : ackSelQ;
    if (!sCtl.enable)
    begin
      sStD = S_IDLE;
      sSdaD = 1'b0;
    end
    else if (stopDet)
    begin
      // Only a stop closing an addressed transfer is flagged
      if (isAddrQ)
        apifD = 1'b1;
      isAddrD = 1'b0;
      if (sStQ == S_ADDR && sCntQ == 4'h0)
        sBerD = 1'b1;
      sSdaD = 1'b0;
      sStD = S_IDLE;
    end
    else if (startDet)
    begin
      sStD = S_ADDR;
      sCntD = 4'h0;
      sSdaD = 1'b0;
      collD = 1'b0;
      sBerD = 1'b0;
    end
    else
    begin
      if (sclRise)
        sCntD = sCntQ + 4'h1;
      if (inAck && !sclS && sCntQ == BYTE_BITS && !difQ && !apifQ)
        sSdaD = (ackSelQ == ACK_SEND);
      case (sStQ)
        S_ADDR, S_RXD:
          if (sclRise)
          begin
            sShD = inByte;
            if (sCntQ == LAST_DATA_BIT && sStQ == S_RXD)
            begin
              sByteD = inByte;
              difD = 1'b1;
              sStD = S_DACK;
            end
            else if (sCntQ == LAST_DATA_BIT && addrMatch)
            begin
              sByteD = inByte;
              sDirD = sdaS;
              apifD = 1'b1;
              isAddrD = 1'b1;
              sStD = S_AACK;
            end
            else if (sCntQ == LAST_DATA_BIT)
              sStD = S_IDLE;
          end
        S_AACK, S_DACK:
          if (sclFall && sCntQ == FRAME_BITS)
          begin
            sSdaD = 1'b0;
            sCntD = 4'h0;
            if (ackSelQ != ACK_SEND)
              sStD = S_IDLE;
            else if (sStQ == S_DACK || !sDirQ)
              sStD = S_RXD;
            else
            begin
              difD = 1'b1;
              sStD = S_TXW;
            end
          end
        S_TXW:
          if (slaveByteWrite)
          begin
            sTxD = slaveByteWriteData;
            sSdaD = ~slaveByteWriteData[7];
            sCntD = 4'h0;
            sStD = S_TXB;
          end
        S_TXB:
        begin
          if (sclFall && sCntQ != 4'h0 && sCntQ < BYTE_BITS)
            sTxD = {sTxQ[6:0], 1'b0};
          if (!sclS)
            sSdaD = (sCntQ < BYTE_BITS) ? ~sTxQ[7] : 1'b0;
          if (sclRise && sCntQ < BYTE_BITS && sTxQ[7] && !sdaS)
          begin
            collD = 1'b1;
            sSdaD = 1'b0;
            sStD = S_IDLE;
          end
          else if (sclRise && sCntQ == BYTE_BITS)
            sRxAckD = sdaS;
          else if (sclFall && sCntQ == FRAME_BITS)
          begin
            sSdaD = 1'b0;
            if (sRxAckQ == ACK_SEND)
            begin
              difD = 1'b1;
              sStD = S_TXW;
            end
            else
              sStD = S_IDLE;
          end
        end
        default:
          sStD = S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State and pin registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      {sclP, sdaP, busBusyQ, mHoldQ, respQ, sHoldQ, wakeQ} <= 7'h60;
      mStQ <= M_IDLE;
      phaseQ <= P_ADDR;
      {tmrQ, txQ, rxQ, nBitsQ, addrQ, mByteQ, pendQ} <= 49'h0;
      {dirQ, needAckQ, mSclQ, mSdaQ, rifQ, wifQ, arbQ, berQ, rxAckQ} <= 9'h000;
      sStQ <= S_IDLE;
      {sCntQ, sShQ, sTxQ, sByteQ} <= 28'h0;
      {difQ, apifQ, isAddrQ, sDirQ, collQ, sBerQ, sRxAckQ, sSdaQ} <= 8'h00;
      ackSelQ <= ACK_SEL_RESET;
      {sclOut, sclOe, sdaOut, sdaOe, masterIrq, slaveIrq} <= 6'h00;
    end
    else
    begin
      sclP <= sclS;
      sdaP <= sdaS;
      busBusyQ <= startDet | (busBusyQ & ~stopDet);
      mStQ <= mStD;
      phaseQ <= phaseD;
      {tmrQ, txQ, rxQ, nBitsQ, addrQ, mByteQ, pendQ} <=
        {tmrD, txD, rxD, nBitsD, addrD, mByteD, pendD};
      {dirQ, needAckQ, mSclQ, mSdaQ} <= {dirD, needAckD, mSclD, mSdaD};
      {rifQ, wifQ, arbQ, berQ, rxAckQ} <= {rifD, wifD, arbD, berD, rxAckD};
      mHoldQ <= (mStD == M_HOLD);
      sStQ <= sStD;
      {sCntQ, sShQ, sTxQ, sByteQ} <= {sCntD, sShD, sTxD, sByteD};
      {difQ, apifQ, isAddrQ, sDirQ} <= {difD, apifD, isAddrD, sDirD};
      {collQ, sBerQ, sRxAckQ, sSdaQ, ackSelQ} <= {collD, sBerD, sRxAckD, sSdaD, ackSelD};
      respQ <= respond;
      wakeQ <= sleepMode & (wakeQ | startDet);
      sHoldQ <= (difQ | apifQ | respQ | wakeQ) & (~sclS | sHoldQ);
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
      sclOe <= mSclQ | (sHoldQ & ~collQ);
      sdaOe <= mSdaQ | (sSdaQ & ~collQ);
      masterIrq <= (rifQ & mCtl.readIntEnable) | (wifQ & mCtl.writeIntEnable);
      slaveIrq <= (difQ & sCtl.dataIntEnable) | (apifQ & sCtl.addrStopIntEnable);
    end
  end

  assign mStat = '{rifQ, wifQ, mHoldQ, rxAckQ, arbQ, berQ};
  assign masterByte = mByteQ;
  assign sStat = '{difQ, apifQ, sHoldQ, sRxAckQ, collQ, sBerQ, sDirQ, isAddrQ};
  assign slaveByte = sByteQ;
endmodule : twms_top

/* File: bench/twms_bus_peer.sv */
// Bus peer model: a slave that answers the ninth bit of each frame.
// Assumes open-drain lines resolved in the bench with pull-ups.
`timescale 1ns/100ps
module twms_bus_peer (
  input wire logic scl,
  input wire logic sda,
  input wire logic nackAll,
  output logic sdaPull
);
  // --
  // Frame tracking
  // --
  int bitCnt = 0;
  initial sdaPull = 0;
  always @(negedge sda)
    if (scl)
      bitCnt = 0;
  always @(posedge scl)
    bitCnt = bitCnt + 1;
  always @(negedge scl)
    sdaPull = (bitCnt % 9 == 8) && !nackAll;
endmodule : twms_bus_peer

/* File: bench/twms_assertions.sv */
// Checker on the two-wire controller top ports.
// Assumes a bind onto twms_top from the bench top file.
`timescale 1ns/100ps
module twms_assertions (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sclIn,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaOut,
  input wire logic sleepMode,
  input twms_pkg::twms_mctl_s mCtl,
  input wire logic byteWrite,
  input wire logic cmdWrite,
  input wire logic [1:0] cmdCode,
  input twms_pkg::twms_mstat_s mStat,
  input wire logic masterIrq,
  input twms_pkg::twms_sctl_s sCtl,
  input twms_pkg::twms_sstat_s sStat,
  input wire logic slaveIrq
);
  import twms_pkg::*;
  // --
  // Properties
  // --
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  wire live = mCtl.enable & !sleepMode & mStat.clkHold;
  wire sFlag = sStat.slaveByteFlag | sStat.addrOrStopFlag;
  wire mReq = (mStat.readDoneFlag & mCtl.readIntEnable) | (mStat.writeDoneFlag & mCtl.writeIntEnable);
  wire sReq = (sStat.slaveByteFlag & sCtl.dataIntEnable) | (sStat.addrOrStopFlag & sCtl.addrStopIntEnable);
  a_master_irq: assert property (masterIrq == $past(mReq))
    else $error("master request mismatch");
  a_slave_irq: assert property (slaveIrq == $past(sReq))
    else $error("slave request mismatch");
  a_wd_clear: assert property (byteWrite && live && mStat.writeDoneFlag && !mStat.readDoneFlag
    && !mCtl.quickCommandEnable |-> ##[1:2] !mStat.writeDoneFlag)
    else $error("write done not cleared");
  a_cmd_clear: assert property (cmdWrite && cmdCode != CMD_NONE && live
    |-> ##[1:2] !(mStat.readDoneFlag | mStat.writeDoneFlag))
    else $error("command left a flag set");
  a_slave_hold: assert property (sFlag && !sclIn |-> ##[0:4] (sclOe || !sFlag))
    else $error("slave flag without clock hold");
  a_out_zero: assert property (!sclOut && !sdaOut)
    else $error("open drain data not low");
  a_sleep_freeze: assert property (sleepMode && $past(sleepMode) |-> $stable(mStat))
    else $error("master moved in sleep");
  a_stop_release: assert property (cmdWrite && cmdCode == CMD_STOP && live
    |-> ##[1:100] !sclOe)
    else $error("stop did not release clock");
  cover property ($rose(sStat.addrOrStopFlag));
  cover property ($rose(sStat.slaveByteFlag));
  cover property ($rose(mStat.readDoneFlag));
endmodule : twms_assertions

/* File: bench/two_wire_master_slave_transfer_bench.sv */
// Self-checking bench for the two-wire controller top.
// Assumes one peer slave on the bus and the design's own slave at 0x2A.
`timescale 1ns/100ps
module two_wire_master_slave_transfer_bench;
  import twms_pkg::*;
  // --
  // Harness
  // --
  logic mclk = 0, rst_b = 0, sleepMode = 0, nackAll = 0;
  logic targetWrite = 0, byteWrite = 0, cmdWrite = 0, slaveRespond = 0;
  logic [7:0] targetData = 8'h00, byteWriteData = 8'h00;
  logic mRead = 0, sTxWrite = 0;
  logic [7:0] sTxByte = 8'h00;
  logic [1:0] cmdCode = 2'h0;
  twms_mctl_s mCtl = '0;
  twms_sctl_s sCtl = '0;
  twms_mstat_s mStat;
  twms_sstat_s sStat;
  logic sclOe, sdaOe, masterIrq, slaveIrq, peerPull;
  logic [7:0] masterByte, slaveByte;
  int num_errors = 0, n_checks = 0;
  wire scl = !sclOe;
  wire sda = !(sdaOe | peerPull);
  wire [3:0] fl = {sStat.slaveByteFlag, sStat.addrOrStopFlag, mStat.readDoneFlag, mStat.writeDoneFlag};
  always #4 mclk = !mclk;
  twms_top dut (.mclk, .rst_b, .sclIn(scl), .sdaIn(sda), .sclOut(), .sclOe, .sdaOut(), .sdaOe,
    .sleepMode, .mCtl, .targetWrite, .targetData, .byteWrite, .byteWriteData, .byteRead(mRead),
    .cmdWrite, .cmdCode, .mStat, .masterByte, .masterIrq, .sCtl, .slaveRespond,
    .slaveByteWrite(sTxWrite), .slaveByteWriteData(sTxByte), .slaveByteRead(1'b0), .sStat,
    .slaveByte, .slaveIrq);
  twms_bus_peer peer (.scl, .sda, .nackAll, .sdaPull(peerPull));
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask : tick
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic chb(input logic seen, input logic exp);
    chk({7'h00, seen}, {7'h00, exp});
  endtask : chb
  task automatic mreq(input logic [1:0] k, input logic [7:0] d);
    targetData = d;
    byteWriteData = d;
    cmdCode = d[1:0];
    targetWrite = k == 2'h0;
    byteWrite = k == 2'h1;
    cmdWrite = k == 2'h2;
    tick();
    {targetWrite, byteWrite, cmdWrite} = 3'h0;
  endtask : mreq
  task automatic respond();
    slaveRespond = 1;
    tick();
    slaveRespond = 0;
  endtask : respond
  task automatic waitf(input int i);
    int n;
    n = 0;
    while (fl[i] !== 1'b1 && n < 3000)
    begin
      tick();
      n++;
    end
    chb(fl[i], 1'b1);
  endtask : waitf
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  // --
  // Scenarios
  // --
  task automatic ext_write();
    mCtl.writeIntEnable = 1;
    mreq(2'h0, 8'hA0);
    waitf(0);
    chb(mStat.receivedAckStatus, ACK_SEND);
    tick();
    chb(masterIrq, 1'b1);
    mCtl.writeIntEnable = 0;
    nackAll = 1;
    mreq(2'h1, 8'h3C);
    tick();
    chb(mStat.writeDoneFlag, 1'b0);
    waitf(0);
    tick();
    chb(masterIrq, 1'b0);
    chb(mStat.receivedAckStatus, 1'b1);
    mreq(2'h2, {6'h00, CMD_STOP});
    repeat (80) tick();
    chb(sclOe | sdaOe, 1'b0);
    nackAll = 0;
  endtask : ext_write
  task automatic quick_read();
    mCtl.quickCommandEnable = 1;
    mreq(2'h0, 8'hA1);
    waitf(1);
    chb(mStat.writeDoneFlag, 1'b0);
    repeat (40) tick();
    chb(sdaOe, 1'b0);
    mreq(2'h2, {6'h00, CMD_STOP});
    repeat (80) tick();
    chb(fl[1], 1'b0);
    mCtl.quickCommandEnable = 0;
  endtask : quick_read
  task automatic own_slave();
    nackAll = 1;
    mreq(2'h0, 8'h54);
    waitf(2);
    chb(sStat.isAddress, 1'b1);
    chb(sStat.direction, 1'b0);
    chk(slaveByte, 8'h54);
    repeat (20) tick();
    chb(slaveIrq & sclOe, 1'b1);
    respond();
    waitf(0);
    chb(mStat.receivedAckStatus, 1'b0);
    mreq(2'h1, 8'hA5);
    waitf(3);
    chk(slaveByte, 8'hA5);
    respond();
    waitf(0);
    chb(mStat.receivedAckStatus, 1'b0);
    mreq(2'h2, {6'h00, CMD_STOP});
    waitf(2);
    chb(sStat.isAddress, 1'b0);
    respond();
    mreq(2'h0, 8'h56);
    waitf(0);
    chk({6'h00, mStat.receivedAckStatus, fl[2]}, 8'h02);
    mreq(2'h2, {6'h00, CMD_STOP});
    repeat (80) tick();
    respond();
    nackAll = 0;
  endtask : own_slave
  task automatic slave_send(input logic [7:0] d);
    waitf(3);
    sTxByte = d;
    sTxWrite = 1;
    tick();
    sTxWrite = 0;
    respond();
    waitf(1);
    chk(masterByte, d);
  endtask : slave_send
  task automatic slave_read();
    nackAll = 1;
    mCtl.autoAckEnable = 1;
    mreq(2'h0, 8'h55);
    waitf(2);
    chb(sStat.direction, 1'b1);
    respond();
    slave_send(8'hC3);
    mRead = 1;
    tick();
    mRead = 0;
    slave_send(8'h5A);
    mCtl.ackResponseSelect = 1;
    mreq(2'h2, {6'h00, CMD_STOP});
    repeat (80) tick();
    chb(sStat.receivedAckStatus, 1'b1);
    chb(fl[2], 1'b1);
    respond();
    mCtl.ackResponseSelect = 0;
    mCtl.autoAckEnable = 0;
    nackAll = 0;
  endtask : slave_read
  task automatic sleep_hold();
    sleepMode = 1;
    mreq(2'h0, 8'hA0);
    repeat (40) tick();
    chb(sdaOe | fl[0], 1'b0);
    sleepMode = 0;
  endtask : sleep_hold
  initial
  begin
    mCtl.enable = 1;
    sCtl.enable = 1;
    sCtl.address = 7'h2A;
    sCtl.dataIntEnable = 1;
    sCtl.addrStopIntEnable = 1;
    repeat (8) tick();
    rst_b = 1;
    repeat (3) tick();
    ext_write();
    quick_read();
    own_slave();
    slave_read();
    sleep_hold();
    finish_test();
  end
  initial
  begin
    repeat (40000) @(posedge mclk);
    num_errors++;
    finish_test();
  end
endmodule : two_wire_master_slave_transfer_bench
bind twms_top twms_assertions chk_i (.mclk, .rst_b, .sclIn, .sclOut, .sclOe, .sdaOut,
  .sleepMode, .mCtl, .byteWrite, .cmdWrite, .cmdCode, .mStat, .masterIrq, .sCtl, .sStat,
  .slaveIrq);
